// [core/ieh_top.sv]
// Contract
// - Enable write with data bit 7 low clears enables marked by ones.
// - Enable write with data bit 7 high sets enables marked by ones.
// - Enable read returns seven enables, bit 7 reads zero.
// - Control bit 0 picks falling or rising strobe A edge for its flag.
// - A handshake input: bit 2 picks edge, bit 1 stops port A clears.
// - Independent input flags clear only by writing one to the flag.
// - A handshake output: port A access drives low, strobe edge restores.
// - A pulse output: one cycle low after any port A access.
// - A manual modes: code 110 holds low, 111 holds high.
// - Control bit 4 picks strobe B edge; port B access clears flag.
// - Strobe B flag still set by pin edges during serial use.
// - B handshake line belongs to serial function while shifter active.
// - B handshake input: bit 6 picks edge, bit 5 stops port B clears.
// - B handshake output: only port B write drives low, strobe restores.
// - B pulse output: one cycle low after each port B write.
// - B manual modes: code 110 holds low, 111 holds high.
// - Aux modes: timer1 7..6, timer2 5, shifter 4..2, latches 1, 0.
// - Enabled latch captures port A on strobe flag set, holds while set.
// - Aux bit 0 enables latching; otherwise port A reads pass through.
// - Port A reads return pin levels, never the output register.
// - Request low when any enabled flag set; flag bit 7 mirrors it.
// - Writing one to a flag clears it; zeros leave flags alone.
`timescale 1ns/10ps
`default_nettype none

module ieh_top
  import ieh_pkg::*;
(
  input  wire logic       ref_clk_in,
  input  wire logic       rst_in,
  input  wire logic       cs1_in,
  input  wire logic       cs2_n_in,
  input  wire logic [3:0] reg_sel_in,
  input  wire logic       rw_in,
  input  wire logic [7:0] data_in,
  output logic      [7:0] data_out,
  output logic            data_oe_out,
  output logic            irq_n_out,
  input  wire logic       a_side_strobe_in,
  input  wire logic       a_side_handshake_line_in,
  output logic            a_side_handshake_line_out,
  output logic            a_side_handshake_line_oe_out,
  input  wire logic       b_side_strobe_line_in,
  input  wire logic       b_side_handshake_line_in,
  output logic            b_side_handshake_line_out,
  output logic            b_side_handshake_line_oe_out,
  input  wire logic [7:0] port_a_pins_in,
  output logic      [7:0] port_a_pins_out,
  output logic      [7:0] port_a_pins_oe_out,
  input  wire logic [7:0] port_b_pins_in,
  output logic      [7:0] port_b_pins_out,
  output logic      [7:0] port_b_pins_oe_out,
  input  wire logic       timer1_event_in,
  input  wire logic       timer2_event_in,
  input  wire logic       serial_event_in,
  input  wire logic       serial_active_in,
  input  wire logic       serial_line_in,
  input  wire logic       serial_line_oe_in,
  output logic      [1:0] timer1_mode_out,
  output logic            timer2_mode_out,
  output logic      [2:0] serial_mode_out,
  output logic            port_b_latch_en_out
);

  ieh_state_s q;
  ieh_state_s next_q;
  logic [19:0] sync_bus;
  logic [3:0]  lines;
  logic [7:0]  pa_pins;
  logic [7:0]  pb_pins;
  logic        acc;
  logic        acc_ora;
  logic        acc_orb;
  logic        wr_orb;
  logic [2:0]  a_mode;
  logic [2:0]  b_mode;
  logic        ca1_edge;
  logic        ca2_edge;
  logic        cb1_edge;
  logic        cb2_edge;
  logic        irq_any;

  // true when line moved to the level selected by rise
  function automatic logic edge_hit(input logic prev_lvl,
                                    input logic cur_lvl,
                                    input logic rise);
    edge_hit = rise ? (!prev_lvl && cur_lvl) : (prev_lvl && !cur_lvl);
  endfunction

  ieh_sync #(
    .WIDTH (20)
  ) u_sync (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .async_in   ({port_b_pins_in, port_a_pins_in, b_side_handshake_line_in,
                  b_side_strobe_line_in, a_side_handshake_line_in,
                  a_side_strobe_in}),
    .sync_out   (sync_bus)
  );

  assign lines   = sync_bus[3:0];
  assign pa_pins = sync_bus[11:4];
  assign pb_pins = sync_bus[19:12];

  assign acc     = cs1_in && !cs2_n_in;
  assign acc_ora = acc && (reg_sel_in == ADDR_ORA);
  assign acc_orb = acc && (reg_sel_in == ADDR_ORB);
  assign wr_orb  = acc_orb && !rw_in;
  assign a_mode  = q.control_line_modes[PCR_CA2_HI:PCR_CA2_LO];
  assign b_mode  = q.control_line_modes[PCR_CB2_HI:PCR_CB2_LO];

  // edges judged on synchronised levels only
  assign ca1_edge = edge_hit(q.prev[LN_CA1], lines[LN_CA1],
                             q.control_line_modes[PCR_CA1_EDGE]);
  assign ca2_edge = !a_mode[2] && edge_hit(q.prev[LN_CA2], lines[LN_CA2],
                                           a_mode[1]);
  // strobe B flag follows pin edges whether or not the shifter uses it
  assign cb1_edge = edge_hit(q.prev[LN_CB1], lines[LN_CB1],
                             q.control_line_modes[PCR_CB1_EDGE]);
  assign cb2_edge = !b_mode[2] && !serial_active_in &&
                    edge_hit(q.prev[LN_CB2], lines[LN_CB2],
                             b_mode[1]);

  assign irq_any = |(q.interrupt_flag_bank & q.interrupt_enable_mask);

  always_comb
  begin
    logic [6:0] set_f;
    logic [6:0] clr_f;
    set_f  = '0;
    clr_f  = '0;
    next_q = q;
    next_q.prev      = lines;
    next_q.rd_en     = acc && rw_in;
    next_q.irq_n     = !irq_any;
    next_q.ca2_pulse = 1'b0;
    next_q.cb2_pulse = 1'b0;

    set_f[FLAG_CA2] = ca2_edge;
    set_f[FLAG_CA1] = ca1_edge;
    set_f[FLAG_SR]  = serial_event_in;
    set_f[FLAG_CB2] = cb2_edge;
    set_f[FLAG_CB1] = cb1_edge;
    set_f[FLAG_T2]  = timer2_event_in;
    set_f[FLAG_T1]  = timer1_event_in;

    if (acc_ora)
    begin
      clr_f[FLAG_CA1] = 1'b1;
      // independent input and output modes leave the flag alone
      clr_f[FLAG_CA2] = !a_mode[2] && !a_mode[0];
    end
    if (acc_orb)
    begin
      clr_f[FLAG_CB1] = 1'b1;
      clr_f[FLAG_CB2] = !b_mode[2] && !b_mode[0];
    end
    if (acc && !rw_in && (reg_sel_in == ADDR_IFR))
      clr_f = clr_f | data_in[6:0];

    // a set arriving with its clear wins
    next_q.interrupt_flag_bank = (q.interrupt_flag_bank & ~clr_f) | set_f;

    if (acc && !rw_in)
    begin
      case (reg_sel_in)
        ADDR_ORB:    next_q.port_b_output_reg  = data_in;
        ADDR_ORA:    next_q.port_a_output_reg  = data_in;
        ADDR_ORA_NH: next_q.port_a_output_reg  = data_in;
        ADDR_DDRB:   next_q.ddrb = data_in;
        ADDR_DDRA:   next_q.ddra = data_in;
        ADDR_ACR:    next_q.aux_function_modes  = data_in;
        ADDR_PCR:    next_q.control_line_modes  = data_in;
        ADDR_IER:
        begin
          if (data_in[IER_SET])
            next_q.interrupt_enable_mask = q.interrupt_enable_mask | data_in[6:0];
          else
            next_q.interrupt_enable_mask = q.interrupt_enable_mask & ~data_in[6:0];
        end
        default:     next_q.interrupt_enable_mask  = q.interrupt_enable_mask;
      endcase
    end

    // port A latch: captured as the strobe flag sets, held while set
    if (!q.aux_function_modes[ACR_PA_LATCH])
      next_q.pa_latch = pa_pins;
    else if (ca1_edge && !q.interrupt_flag_bank[FLAG_CA1])
      next_q.pa_latch = pa_pins;

    // A handshake line output
    if (a_mode == MODE_HANDSHAKE)
    begin
      if (ca1_edge)
        next_q.ca2_lvl = 1'b1;
      if (acc_ora)
        next_q.ca2_lvl = 1'b0;
    end
    else
      next_q.ca2_lvl = 1'b1;
    next_q.ca2_pulse = (a_mode == MODE_PULSE) && acc_ora;

    // B handshake line output, writes only
    if (b_mode == MODE_HANDSHAKE)
    begin
      if (cb1_edge)
        next_q.cb2_lvl = 1'b1;
      if (wr_orb)
        next_q.cb2_lvl = 1'b0;
    end
    else
      next_q.cb2_lvl = 1'b1;
    next_q.cb2_pulse = (b_mode == MODE_PULSE) && wr_orb;

    if (acc && rw_in)
    begin
      case (reg_sel_in)
        ADDR_ORB:    next_q.rdata = (q.port_b_output_reg & q.ddrb) | (pb_pins & ~q.ddrb);
        // pins through the latch, never the output register
        ADDR_ORA:    next_q.rdata = q.aux_function_modes[ACR_PA_LATCH] ? q.pa_latch
                                                        : pa_pins;
        ADDR_ORA_NH: next_q.rdata = q.aux_function_modes[ACR_PA_LATCH] ? q.pa_latch
                                                        : pa_pins;
        ADDR_DDRB:   next_q.rdata = q.ddrb;
        ADDR_DDRA:   next_q.rdata = q.ddra;
        ADDR_ACR:    next_q.rdata = q.aux_function_modes;
        ADDR_PCR:    next_q.rdata = q.control_line_modes;
        ADDR_IFR:    next_q.rdata = {irq_any, q.interrupt_flag_bank};
        ADDR_IER:    next_q.rdata = {1'b0, q.interrupt_enable_mask};
        default:     next_q.rdata = REG_RESET;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      q           <= '0;
      q.interrupt_enable_mask       <= IER_RESET;
      q.interrupt_flag_bank       <= IFR_RESET;
      q.control_line_modes       <= PCR_RESET;
      q.aux_function_modes       <= ACR_RESET;
      q.irq_n     <= 1'b1;
      q.ca2_lvl   <= 1'b1;
      q.cb2_lvl   <= 1'b1;
    end
    else
      q <= next_q;
  end

  always_comb
  begin
    a_side_handshake_line_oe_out = a_mode[2];
    case (a_mode)
      MODE_HANDSHAKE: a_side_handshake_line_out = q.ca2_lvl;
      MODE_PULSE:     a_side_handshake_line_out = !q.ca2_pulse;
      MODE_MAN_LOW:   a_side_handshake_line_out = 1'b0;
      MODE_MAN_HIGH:  a_side_handshake_line_out = 1'b1;
      default:        a_side_handshake_line_out = 1'b1;
    endcase
  end

  always_comb
  begin
    if (serial_active_in)
    begin
      b_side_handshake_line_out    = serial_line_in;
      b_side_handshake_line_oe_out = serial_line_oe_in;
    end
    else
    begin
      b_side_handshake_line_oe_out = b_mode[2];
      case (b_mode)
        MODE_HANDSHAKE: b_side_handshake_line_out = q.cb2_lvl;
        MODE_PULSE:     b_side_handshake_line_out = !q.cb2_pulse;
        MODE_MAN_LOW:   b_side_handshake_line_out = 1'b0;
        MODE_MAN_HIGH:  b_side_handshake_line_out = 1'b1;
        default:        b_side_handshake_line_out = 1'b1;
      endcase
    end
  end

  assign data_out            = q.rdata;
  assign data_oe_out         = q.rd_en;
  assign irq_n_out           = q.irq_n;
  assign port_a_pins_out     = q.port_a_output_reg;
  assign port_a_pins_oe_out  = q.ddra;
  assign port_b_pins_out     = q.port_b_output_reg;
  assign port_b_pins_oe_out  = q.ddrb;
  assign timer1_mode_out     = q.aux_function_modes[ACR_T1_HI:ACR_T1_LO];
  assign timer2_mode_out     = q.aux_function_modes[ACR_T2_MODE];
  assign serial_mode_out     = q.aux_function_modes[ACR_SR_HI:ACR_SR_LO];
  assign port_b_latch_en_out = q.aux_function_modes[ACR_PB_LATCH];

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (rst_in);

  property p_ier_clear;
    (acc && !rw_in && reg_sel_in == ADDR_IER && !data_in[IER_SET])
      |=> (q.interrupt_enable_mask == ($past(q.interrupt_enable_mask) & ~$past(data_in[6:0])));
  endproperty
  a_ier_clear: assert property (p_ier_clear)
    else $error("enable clear write wrong");

  property p_ier_set;
    (acc && !rw_in && reg_sel_in == ADDR_IER && data_in[IER_SET])
      |=> (q.interrupt_enable_mask == ($past(q.interrupt_enable_mask) | $past(data_in[6:0])));
  endproperty
  a_ier_set: assert property (p_ier_set)
    else $error("enable set write wrong");

  property p_ier_read;
    (acc && rw_in && reg_sel_in == ADDR_IER)
      |=> (data_oe_out && data_out == {1'b0, $past(q.interrupt_enable_mask)});
  endproperty
  a_ier_read: assert property (p_ier_read)
    else $error("enable read wrong");

  property p_ca1_flag;
    ca1_edge |=> q.interrupt_flag_bank[FLAG_CA1];
  endproperty
  a_ca1_flag: assert property (p_ca1_flag)
    else $error("strobe A edge did not set flag");

  property p_indep_hold;
    (q.interrupt_flag_bank[FLAG_CA2] && !a_mode[2] && a_mode[0] && acc_ora &&
     !(acc && !rw_in && reg_sel_in == ADDR_IFR)) |=> q.interrupt_flag_bank[FLAG_CA2];
  endproperty
  a_indep_hold: assert property (p_indep_hold)
    else $error("independent flag cleared by port access");

  property p_ca2_hs;
    (a_mode == MODE_HANDSHAKE && acc_ora && !(acc && !rw_in &&
     reg_sel_in == ADDR_PCR)) |=> !a_side_handshake_line_out;
  endproperty
  a_ca2_hs: assert property (p_ca2_hs)
    else $error("A handshake line not driven low");

  property p_ca2_pulse;
    (a_mode == MODE_PULSE && acc_ora) ##1 (a_mode == MODE_PULSE && !acc_ora)
      |-> !a_side_handshake_line_out ##1 a_side_handshake_line_out;
  endproperty
  a_ca2_pulse: assert property (p_ca2_pulse)
    else $error("A pulse not exactly one cycle");

  property p_ca2_manual;
    (a_mode == MODE_MAN_LOW) |-> (a_side_handshake_line_oe_out &&
                                  !a_side_handshake_line_out);
  endproperty
  a_ca2_manual: assert property (p_ca2_manual)
    else $error("A manual low not held");

  property p_cb2_read_no_hs;
    (b_mode == MODE_HANDSHAKE && !serial_active_in && q.cb2_lvl &&
     acc_orb && rw_in) |=> q.cb2_lvl;
  endproperty
  a_cb2_read_no_hs: assert property (p_cb2_read_no_hs)
    else $error("B handshake moved on a read");

  property p_irq;
    irq_any |=> !irq_n_out;
  endproperty
  a_irq: assert property (p_irq)
    else $error("request not asserted");

endmodule // ieh_top

`default_nettype wire

// [core/ieh_pkg.sv]
package ieh_pkg;

  // register select codes
  localparam logic [3:0] ADDR_ORB    = 4'h0;
  localparam logic [3:0] ADDR_ORA    = 4'h1;
  localparam logic [3:0] ADDR_DDRB   = 4'h2;
  localparam logic [3:0] ADDR_DDRA   = 4'h3;
  localparam logic [3:0] ADDR_ACR    = 4'hB;
  localparam logic [3:0] ADDR_PCR    = 4'hC;
  localparam logic [3:0] ADDR_IFR    = 4'hD;
  localparam logic [3:0] ADDR_IER    = 4'hE;
  localparam logic [3:0] ADDR_ORA_NH = 4'hF;

  // flag / enable bit positions
  localparam int FLAG_CA2 = 0;
  localparam int FLAG_CA1 = 1;
  localparam int FLAG_SR  = 2;
  localparam int FLAG_CB2 = 3;
  localparam int FLAG_CB1 = 4;
  localparam int FLAG_T2  = 5;
  localparam int FLAG_T1  = 6;
  localparam int IER_SET  = 7;

  // control_line_modes fields
  localparam int PCR_CA1_EDGE = 0;
  localparam int PCR_CA2_LO   = 1;
  localparam int PCR_CA2_HI   = 3;
  localparam int PCR_CB1_EDGE = 4;
  localparam int PCR_CB2_LO   = 5;
  localparam int PCR_CB2_HI   = 7;

  // aux_function_modes fields
  localparam int ACR_PA_LATCH = 0;
  localparam int ACR_PB_LATCH = 1;
  localparam int ACR_SR_LO    = 2;
  localparam int ACR_SR_HI    = 4;
  localparam int ACR_T2_MODE  = 5;
  localparam int ACR_T1_LO    = 6;
  localparam int ACR_T1_HI    = 7;

  // handshake line mode codes
  localparam logic [2:0] MODE_HANDSHAKE = 3'h4;
  localparam logic [2:0] MODE_PULSE     = 3'h5;
  localparam logic [2:0] MODE_MAN_LOW   = 3'h6;
  localparam logic [2:0] MODE_MAN_HIGH  = 3'h7;

  // reset values
  localparam logic [6:0] IER_RESET = 7'h00;
  localparam logic [6:0] IFR_RESET = 7'h00;
  localparam logic [7:0] PCR_RESET = 8'h00;
  localparam logic [7:0] ACR_RESET = 8'h00;
  localparam logic [7:0] REG_RESET = 8'h00;

  // synchronised line bundle positions
  localparam int LN_CA1 = 0;
  localparam int LN_CA2 = 1;
  localparam int LN_CB1 = 2;
  localparam int LN_CB2 = 3;

  typedef struct packed {
    logic [6:0] interrupt_enable_mask;
    logic [6:0] interrupt_flag_bank;
    logic [7:0] control_line_modes;
    logic [7:0] aux_function_modes;
    logic [7:0] port_a_output_reg;
    logic [7:0] port_b_output_reg;
    logic [7:0] ddra;
    logic [7:0] ddrb;
    logic [7:0] pa_latch;
    logic [7:0] rdata;
    logic       rd_en;
    logic       irq_n;
    logic       ca2_lvl;
    logic       cb2_lvl;
    logic       ca2_pulse;
    logic       cb2_pulse;
    logic [3:0] prev;
  } ieh_state_s;

endpackage

// [core/ieh_sync.sv]
`timescale 1ns/10ps
`default_nettype none

module ieh_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             ref_clk_in,
  input  wire logic             rst_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  if (WIDTH < 1)
  begin : g_bad_width
    $error("ieh_sync: WIDTH must be at least 1");
  end

  // stage1 feeds only the second flop
  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      stage1   <= '0;
      sync_out <= '0;
    end
    else
    begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule // ieh_sync

`default_nettype wire

// [sim/ieh_periph.sv]
`timescale 1ns/10ps
`default_nettype none

module ieh_periph (
  input  wire logic       ref_clk_in,
  input  wire logic       rst_in,
  input  wire logic       ack_en_in,
  input  wire logic [3:0] dly_in,
  input  wire logic [3:0] lvl_in,
  input  wire logic       hs_a_in,
  input  wire logic       hs_a_oe_in,
  input  wire logic       hs_b_in,
  input  wire logic       hs_b_oe_in,
  output logic      [3:0] line_out
);
  logic [4:0] cnt;
  logic       hs_a_w;
  logic       hs_b_w;
  logic       ack;
  // the adapter owns a handshake wire while it drives it
  assign hs_a_w = hs_a_oe_in ? hs_a_in : lvl_in[1];
  assign hs_b_w = hs_b_oe_in ? hs_b_in : lvl_in[3];
  // acknowledge held low until data-ready is withdrawn
  assign ack = ack_en_in && !hs_a_w && (cnt >= {1'b0, dly_in});
  assign line_out = {hs_b_w, lvl_in[2], hs_a_w, lvl_in[0] & ~ack};
  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
      cnt <= 5'h00;
    else if (!ack_en_in || hs_a_w)
      cnt <= 5'h00;
    else if (!cnt[4])
      cnt <= cnt + 5'h01;
  end
endmodule // ieh_periph

`default_nettype wire

// [sim/tb_top.sv]
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  import ieh_pkg::*;
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic cs1_in = 1'b0;
  logic cs2_n_in = 1'b0;
  logic rw_in = 1'b1;
  logic [3:0] reg_sel_in = 4'h0;
  logic [7:0] data_in = 8'h00;
  logic timer1_event_in = 1'b0;
  logic timer2_event_in = 1'b0;
  logic serial_event_in = 1'b0;
  logic serial_active_in = 1'b0;
  logic serial_line_in = 1'b0;
  logic serial_line_oe_in = 1'b0;
  logic [7:0] port_b_pins_in = 8'h00;
  logic [7:0] data_out, port_a_pins_out, port_a_pins_oe_out;
  logic [7:0] port_b_pins_out, port_b_pins_oe_out, port_a_pins_in, modes;
  logic data_oe_out, irq_n_out, timer2_mode_out, port_b_latch_en_out;
  logic a_side_handshake_line_out, a_side_handshake_line_oe_out;
  logic b_side_handshake_line_out, b_side_handshake_line_oe_out;
  logic [1:0] timer1_mode_out;
  logic [2:0] serial_mode_out;
  logic [3:0] lvl = 4'hF;
  logic [3:0] ln;
  logic ack_en = 1'b0;
  logic [3:0] dly = 4'h0;
  logic [7:0] pin_drv = 8'h00;
  int fbit[4] = '{1, 0, 4, 3};
  int num_errors = 0;
  int checks = 0;

  always #12.5 ref_clk_in = ~ref_clk_in;
  assign port_a_pins_in = (port_a_pins_oe_out & port_a_pins_out) |
                          (~port_a_pins_oe_out & pin_drv);
  assign modes = {timer1_mode_out, timer2_mode_out, serial_mode_out,
                  port_b_latch_en_out, 1'b0};

  ieh_top dut (
    .ref_clk_in, .rst_in, .cs1_in, .cs2_n_in, .reg_sel_in, .rw_in,
    .data_in, .data_out, .data_oe_out, .irq_n_out,
    .a_side_strobe_in(ln[0]), .a_side_handshake_line_in(ln[1]),
    .a_side_handshake_line_out, .a_side_handshake_line_oe_out,
    .b_side_strobe_line_in(ln[2]), .b_side_handshake_line_in(ln[3]),
    .b_side_handshake_line_out, .b_side_handshake_line_oe_out,
    .port_a_pins_in, .port_a_pins_out, .port_a_pins_oe_out,
    .port_b_pins_in, .port_b_pins_out, .port_b_pins_oe_out,
    .timer1_event_in, .timer2_event_in, .serial_event_in,
    .serial_active_in, .serial_line_in, .serial_line_oe_in,
    .timer1_mode_out, .timer2_mode_out, .serial_mode_out,
    .port_b_latch_en_out
  );

  ieh_periph periph (
    .ref_clk_in, .rst_in, .ack_en_in(ack_en), .dly_in(dly), .lvl_in(lvl),
    .hs_a_in(a_side_handshake_line_out),
    .hs_a_oe_in(a_side_handshake_line_oe_out),
    .hs_b_in(b_side_handshake_line_out),
    .hs_b_oe_in(b_side_handshake_line_oe_out), .line_out(ln)
  );

  function automatic logic [7:0] hs();
    return {4'h0, a_side_handshake_line_out, a_side_handshake_line_oe_out,
            b_side_handshake_line_out, b_side_handshake_line_oe_out};
  endfunction

  function automatic logic [6:0] en_upd(logic [6:0] q, logic [7:0] d);
    return d[7] ? (q | d[6:0]) : (q & ~d[6:0]);
  endfunction

  task automatic end_of_test();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_in);
  endtask

  task automatic acc(input logic r, input logic [3:0] s,
                     input logic [7:0] d);
    @(posedge ref_clk_in);
    cs1_in <= 1'b1;
    rw_in <= r;
    reg_sel_in <= s;
    data_in <= d;
    @(posedge ref_clk_in);
    cs1_in <= 1'b0;
  endtask

  task automatic rdc(input logic [3:0] s, input logic [7:0] e);
    acc(1'b1, s, 8'h00);
    @(negedge ref_clk_in);
    chk({7'h00, data_oe_out}, 8'h01);
    chk(data_out, e);
  endtask

  task automatic pls(input logic r, input logic [3:0] s,
                     input logic [7:0] e1, input logic [7:0] e2);
    acc(r, s, 8'h5A);
    @(negedge ref_clk_in);
    chk(hs(), e1);
    @(negedge ref_clk_in);
    chk(hs(), e2);
  endtask

  task automatic wait_hs(input logic [7:0] e);
    int n;
    n = 0;
    while (hs() !== e && n < 40)
    begin
      @(negedge ref_clk_in);
      n++;
    end
    chk(hs(), e);
    if (n == 40)
      end_of_test();
  endtask

  // one edge on a control line: set, port access, clear, wrong edge
  task automatic edge_t(input int l, input logic [7:0] control_line_modes,
                        input logic rise, input logic ind);
    logic [7:0] f;
    f = 8'h01 << fbit[l];
    lvl[l] <= !rise;
    acc(1'b0, ADDR_PCR, control_line_modes);
    cyc(5);
    acc(1'b0, ADDR_IFR, 8'h7F);
    lvl[l] <= rise;
    cyc(5);
    rdc(ADDR_IFR, 8'h80 | f);
    chk({7'h00, irq_n_out}, 8'h00);
    acc(1'($urandom), (l < 2) ? ADDR_ORA : ADDR_ORB, 8'hA5);
    rdc(ADDR_IFR, ind ? (8'h80 | f) : 8'h00);
    acc(1'b0, ADDR_IFR, f);
    lvl[l] <= !rise;
    cyc(5);
    rdc(ADDR_IFR, 8'h00);
    chk({7'h00, irq_n_out}, 8'h01);
  endtask

  initial
  begin
    logic [7:0] d;
    logic [7:0] p;
    logic [6:0] en;
    void'($urandom(32'hA10EBE33));
    cyc(8);
    rst_in <= 1'b0;
    rdc(ADDR_IER, 8'h00);
    rdc(ADDR_PCR, 8'h00);
    rdc(ADDR_ACR, 8'h00);
    rdc(4'h5, 8'h00);
    $display("test reset done");
    en = 7'h00;
    for (int i = 0; i < 16; i++)
    begin
      d = (i == 0) ? 8'hFF : (i == 1) ? 8'h2A : 8'($urandom);
      en = en_upd(en, d);
      acc(1'b0, ADDR_IER, d);
      rdc(ADDR_IER, {1'b0, en});
    end
    $display("test enable mask done");
    acc(1'b0, ADDR_IER, 8'h7F);
    {timer1_event_in, timer2_event_in, serial_event_in} <= 3'h7;
    @(posedge ref_clk_in);
    {timer1_event_in, timer2_event_in, serial_event_in} <= 3'h0;
    rdc(ADDR_IFR, 8'h64);
    acc(1'b0, ADDR_IER, 8'h84);
    rdc(ADDR_IFR, 8'hE4);
    chk({7'h00, irq_n_out}, 8'h00);
    acc(1'b0, ADDR_IFR, 8'h84);
    rdc(ADDR_IFR, 8'h60);
    chk({7'h00, irq_n_out}, 8'h01);
    acc(1'b0, ADDR_IFR, 8'h60);
    rdc(ADDR_IFR, 8'h00);
    $display("test request done");
    acc(1'b0, ADDR_IER, 8'hFF);
    for (int e = 0; e < 2; e++)
    begin
      edge_t(0, 8'(e), e[0], 1'b0);
      serial_active_in <= e[0];
      edge_t(2, 8'(e) << 4, e[0], 1'b0);
      serial_active_in <= 1'b0;
    end
    for (int m = 0; m < 4; m++)
    begin
      edge_t(1, 8'(m) << 1, m[1], m[0]);
      edge_t(3, 8'(m) << 5, m[1], m[0]);
    end
    lvl <= 4'hF;
    cyc(5);
    acc(1'b0, ADDR_IFR, 8'h7F);
    $display("test line edges done");
    acc(1'b0, ADDR_PCR, 8'hCC);
    @(negedge ref_clk_in);
    chk(hs(), 8'h05);
    acc(1'b0, ADDR_PCR, 8'hEE);
    @(negedge ref_clk_in);
    chk(hs(), 8'h0F);
    acc(1'b0, ADDR_PCR, 8'hEA);
    pls(1'b0, ADDR_ORA, 8'h07, 8'h0F);
    pls(1'b1, ADDR_ORA, 8'h07, 8'h0F);
    acc(1'b0, ADDR_PCR, 8'hAE);
    pls(1'b1, ADDR_ORB, 8'h0F, 8'h0F);
    pls(1'b0, ADDR_ORB, 8'h0D, 8'h0F);
    acc(1'b0, ADDR_PCR, 8'h8E);
    pls(1'b1, ADDR_ORB, 8'h0F, 8'h0F);
    pls(1'b0, ADDR_ORB, 8'h0D, 8'h0D);
    lvl[2] <= 1'b0;
    wait_hs(8'h0F);
    lvl[2] <= 1'b1;
    for (int k = 0; k < 3; k++)
    begin
      dly <= 4'($urandom);
      ack_en <= 1'b1;
      acc(1'b0, ADDR_PCR, 8'hE8);
      pls(1'($urandom), ADDR_ORA, 8'h07, 8'h07);
      wait_hs(8'h0F);
    end
    @(posedge ref_clk_in);
    ack_en <= 1'b0;
    serial_active_in <= 1'b1;
    for (int k = 0; k < 4; k++)
    begin
      @(posedge ref_clk_in);
      {serial_line_in, serial_line_oe_in} <= 2'(k);
      @(negedge ref_clk_in);
      chk(hs(), {6'h03, 2'(k)});
    end
    @(posedge ref_clk_in);
    serial_active_in <= 1'b0;
    $display("test output modes done");
    d = 8'($urandom) & 8'hFE;
    acc(1'b0, ADDR_ACR, d);
    rdc(ADDR_ACR, d);
    chk(modes, d);
    acc(1'b0, ADDR_PCR, 8'h00);
    acc(1'b0, ADDR_DDRA, 8'h0F);
    @(negedge ref_clk_in);
    chk(port_a_pins_oe_out, 8'h0F);
    p = 8'($urandom);
    acc(1'b0, ADDR_ORA_NH, p);
    pin_drv <= 8'($urandom);
    cyc(4);
    rdc(ADDR_ORA_NH, {pin_drv[7:4], p[3:0]});
    acc(1'b0, ADDR_ACR, 8'h01);
    acc(1'b0, ADDR_IFR, 8'h7F);
    p = {pin_drv[7:4], p[3:0]};
    lvl[0] <= 1'b0;
    cyc(5);
    pin_drv <= ~pin_drv;
    cyc(4);
    rdc(ADDR_ORA_NH, p);
    acc(1'b0, ADDR_ACR, 8'h00);
    rdc(ADDR_ORA_NH, {pin_drv[7:4], p[3:0]});
    // port B reads mix output register and pins by direction
    acc(1'b0, ADDR_DDRB, 8'hF0);
    acc(1'b0, ADDR_ORB, p);
    port_b_pins_in <= 8'($urandom);
    cyc(4);
    chk(port_b_pins_oe_out, 8'hF0);
    chk(port_b_pins_out, p);
    rdc(ADDR_ORB, {p[7:4], port_b_pins_in[3:0]});
    $display("test port latch done");
    end_of_test();
  end
endmodule // tb_top

`default_nettype wire
